// ---- hdl/handler_params.svh ----
// Constants of the handler comparator output stage: register map, fields,
// reset values and widths.
// Assumes inclusion by the package and the top module; no process here.
`ifndef HANDLER_PARAMS_SVH
`define HANDLER_PARAMS_SVH

`define BIN_COUNT 9
`define BIN_IDX_W 4
`define BIN_FIRST 4'h1
`define BIN_LAST 4'h9

`define ADDR_W 5
`define OFF_CTRL 5'h00
`define OFF_STATUS 5'h04
`define OFF_IRQ_STAT 5'h08
`define OFF_IRQ_MASK 5'h0c
`define OFF_COUNT 5'h10

`define CTRL_W 8
`define CTRL_RESET 8'h00
`define CTRL_ENABLE 0
`define CTRL_EDGE_RISING 1
`define CTRL_EXT_MODE 2
`define CTRL_SW_START 3
`define CTRL_SEG_LSB 4
`define CTRL_SEG_MSB 7
`define SEG_W 4

`define STAT_BUSY 0
`define STAT_END 1
`define STAT_FAIL 2
`define STAT_NO_BIN 3
`define STAT_BIN_LSB 4
`define STAT_BIN_MSB 7

`define IRQ_W 4
`define IRQ_RESET 4'h0
`define IRQ_TRIG 0
`define IRQ_END 1
`define IRQ_FAIL 2
`define IRQ_LOST 3

`define COUNT_W 16
`define COUNT_RESET 16'h0000
`define COUNT_STEP 16'h0001

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define DATA_ZERO 32'h0000_0000

`endif

// ---- hdl/handler_pkg.sv ----
// Types shared by the handler comparator output stage.
// Assumes handler_params.svh is on the include path.
`include "handler_params.svh"

package handler_pkg;

    // One bit per comparator line, active high inside the block
    typedef struct packed {
        logic contact_fail;
        logic fail;
        logic secondary_reject;
        logic primary_under;
        logic primary_over;
        logic secondary_miss;
        logic no_bin_match;
        logic [`BIN_COUNT-1:0] bin_lines;
    } comparator_t;

    // Results of one measurement from the measurement engine
    typedef struct packed {
        logic valid;
        logic [`BIN_IDX_W-1:0] bin;
        logic primary_over;
        logic primary_under;
        logic secondary_in_bin;
        logic secondary_reject;
        logic contact_fail;
        logic other_segment_fail;
    } result_t;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_MEASURE
    } meas_state_t;

endpackage

// ---- hdl/trigger_sync.sv ----
// Two-stage synchroniser and selectable edge detector for a pin input.
// Assumes the pin is asynchronous to aclk and pulses last several cycles.
`timescale 1ns/1ps

module trigger_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_level,
    input wire logic rising_sel,
    output logic edge_pulse
);
    logic meta_reg;
    logic stable_reg;
    logic prev_reg;

    // First stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= 1'b1;
            stable_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            meta_reg <= pin_level;
            stable_reg <= meta_reg;
            prev_reg <= stable_reg;
        end
    end

    always_comb begin
        if (rising_sel) begin
            edge_pulse = stable_reg & ~prev_reg;
        end else begin
            edge_pulse = ~stable_reg & prev_reg;
        end
    end
endmodule // trigger_sync

// ---- hdl/oc_driver.sv ----
// Open-collector output stage: a line is pulled low or released.
// Assumes the board supplies the pull-up; level is never driven high.
`timescale 1ns/1ps

module oc_driver #(
    parameter int WIDTH = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic enable,
    input wire logic [WIDTH-1:0] assert_bits,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] drive
);
    logic [WIDTH-1:0] drive_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_reg <= '0;
        end else begin
            drive_reg <= enable ? assert_bits : '0;
        end
    end

    // Asserted means pulled low; released lines float to the pull-up
    assign level = '0;
    assign drive = drive_reg;
endmodule // oc_driver

// ---- hdl/handler_bin_sort_outputs.sv ----
// Comparator output stage of the handler interface, sorting mode with
// nine bins, plus the external trigger input and the cycle-end signal.
// Assumes the measurement engine runs on aclk, starts on meas_start and
// returns one result_t with valid high for one cycle per measurement.
`timescale 1ns/1ps
`include "handler_params.svh"

module handler_bin_sort_outputs (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [`ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Measurement engine
    output logic meas_start,
    output logic [`SEG_W-1:0] sort_segment,
    input wire handler_pkg::result_t result,
    // Handler pins
    input wire logic external_trigger_n,
    output handler_pkg::comparator_t comparator_level,
    output handler_pkg::comparator_t comparator_drive,
    output logic measurement_cycle_end_n,
    output logic irq
);
    import handler_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [`CTRL_W-1:0] ctrl_reg;
    logic [`IRQ_W-1:0] irq_stat_reg;
    logic [`IRQ_W-1:0] irq_mask_reg;
    logic [`COUNT_W-1:0] count_reg;
    logic sw_start_reg;

    logic aw_held_reg;
    logic [`ADDR_W-1:0] aw_addr_reg;
    logic w_held_reg;
    logic [31:0] w_data_reg;
    logic w_lane0_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    meas_state_t state_reg;
    meas_state_t state_next;
    logic meas_start_reg;
    logic eom_n_reg;
    comparator_t held_reg;
    comparator_t comp_next;
    logic [`BIN_IDX_W-1:0] last_bin_reg;

    logic wr_fire;
    logic wr_hit_ctrl;
    logic wr_hit_stat;
    logic wr_hit_mask;
    logic wr_mapped;
    logic rd_fire;
    logic rd_mapped;
    logic [31:0] rd_value;
    logic ext_edge;
    logic trig_fire;
    logic trig_taken;
    logic trig_lost;
    logic result_taken;
    logic bin_ok;
    logic [`IRQ_W-1:0] irq_events;

    // ****************************************************************
    // Register bus: write channel
    // ****************************************************************
    // Address and data are captured on their own; the write is done
    // once both are in and no response is pending.
    assign awready = ~aw_held_reg & ~bvalid_reg;
    assign wready = ~w_held_reg & ~bvalid_reg;
    assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (awvalid && awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= `DATA_ZERO;
            w_lane0_reg <= 1'b0;
        end else if (wvalid && wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= wdata;
            w_lane0_reg <= wstrb[0];
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    // Every writable field sits in byte lane 0, so lane 0 gates all effects
    assign wr_hit_ctrl = wr_fire & w_lane0_reg & (aw_addr_reg == `OFF_CTRL);
    assign wr_hit_stat = wr_fire & w_lane0_reg
                         & (aw_addr_reg == `OFF_IRQ_STAT);
    assign wr_hit_mask = wr_fire & w_lane0_reg
                         & (aw_addr_reg == `OFF_IRQ_MASK);
    assign wr_mapped = (aw_addr_reg == `OFF_CTRL)
                       | (aw_addr_reg == `OFF_STATUS)
                       | (aw_addr_reg == `OFF_IRQ_STAT)
                       | (aw_addr_reg == `OFF_IRQ_MASK)
                       | (aw_addr_reg == `OFF_COUNT);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;

    // ****************************************************************
    // Register bus: read channel
    // ****************************************************************
    assign arready = ~rvalid_reg;
    assign rd_fire = arvalid & arready;

    always_comb begin
        rd_value = `DATA_ZERO;
        rd_mapped = 1'b1;
        case (araddr)
            `OFF_CTRL: begin
                rd_value[`CTRL_W-1:0] = ctrl_reg;
            end
            `OFF_STATUS: begin
                rd_value[`STAT_BUSY] = (state_reg == ST_MEASURE);
                rd_value[`STAT_END] = ~eom_n_reg;
                rd_value[`STAT_FAIL] = held_reg.fail;
                rd_value[`STAT_NO_BIN] = held_reg.no_bin_match;
                rd_value[`STAT_BIN_MSB:`STAT_BIN_LSB] = last_bin_reg;
            end
            `OFF_IRQ_STAT: begin
                rd_value[`IRQ_W-1:0] = irq_stat_reg;
            end
            `OFF_IRQ_MASK: begin
                rd_value[`IRQ_W-1:0] = irq_mask_reg;
            end
            `OFF_COUNT: begin
                rd_value[`COUNT_W-1:0] = count_reg;
            end
            default: begin
                rd_mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= `DATA_ZERO;
            rresp_reg <= `RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_value;
            rresp_reg <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    // ****************************************************************
    // Control, mask and interrupt status
    // ****************************************************************
    // The start bit is not stored; it makes a one-cycle trigger
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `CTRL_RESET;
            sw_start_reg <= 1'b0;
        end else begin
            sw_start_reg <= wr_hit_ctrl & w_data_reg[`CTRL_SW_START];
            if (wr_hit_ctrl) begin
                ctrl_reg <= w_data_reg[`CTRL_W-1:0];
                ctrl_reg[`CTRL_SW_START] <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_reg <= `IRQ_RESET;
        end else if (wr_hit_mask) begin
            irq_mask_reg <= w_data_reg[`IRQ_W-1:0];
        end
    end

    assign irq_events[`IRQ_TRIG] = trig_taken;
    assign irq_events[`IRQ_END] = result_taken;
    assign irq_events[`IRQ_FAIL] = result_taken & comp_next.fail;
    assign irq_events[`IRQ_LOST] = trig_lost;

    // A new event outranks a write-one-to-clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= `IRQ_RESET;
        end else if (wr_hit_stat) begin
            irq_stat_reg <= (irq_stat_reg & ~w_data_reg[`IRQ_W-1:0])
                            | irq_events;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_events;
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ****************************************************************
    // Trigger
    // ****************************************************************
    trigger_sync u_trigger_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_level(external_trigger_n),
        .rising_sel(ctrl_reg[`CTRL_EDGE_RISING]),
        .edge_pulse(ext_edge)
    );

    // External mode listens to the pin only; otherwise the start bit
    assign trig_fire = ctrl_reg[`CTRL_EXT_MODE] ? ext_edge
                                                : sw_start_reg;
    // A trigger while a measurement runs is dropped and flagged
    assign trig_taken = trig_fire & (state_reg == ST_IDLE);
    assign trig_lost = trig_fire & (state_reg == ST_MEASURE);
    assign result_taken = result.valid & (state_reg == ST_MEASURE);

    // ****************************************************************
    // Measurement sequence
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (trig_taken) begin
                    state_next = ST_MEASURE;
                end
            end
            ST_MEASURE: begin
                if (result_taken) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meas_start_reg <= 1'b0;
        end else begin
            meas_start_reg <= trig_taken;
        end
    end

    assign meas_start = meas_start_reg;
    // The engine sorts on this segment and limit-tests the rest
    assign sort_segment = ctrl_reg[`CTRL_SEG_MSB:`CTRL_SEG_LSB];

    // Cycle end is released at a trigger and asserted low together with
    // the new results, so the handler never samples a half update.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eom_n_reg <= 1'b1;
        end else if (result_taken) begin
            eom_n_reg <= 1'b0;
        end else if (trig_taken) begin
            eom_n_reg <= 1'b1;
        end
    end

    assign measurement_cycle_end_n = eom_n_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= `COUNT_RESET;
        end else if (result_taken) begin
            count_reg <= count_reg + `COUNT_STEP;
        end
    end

    // ****************************************************************
    // Classification
    // ****************************************************************
    // Over or under outranks any bin index the engine reports
    assign bin_ok = (result.bin >= `BIN_FIRST) & (result.bin <= `BIN_LAST)
                    & ~result.primary_over & ~result.primary_under;

    always_comb begin
        comp_next = '0;
        for (int i = 0; i < `BIN_COUNT; i++) begin
            // Index match makes the lines one-hot
            comp_next.bin_lines[i] = bin_ok
                & (result.bin == `BIN_IDX_W'(i + 1));
        end
        comp_next.no_bin_match = ~bin_ok;
        comp_next.primary_over = result.primary_over;
        comp_next.primary_under = result.primary_under
                                  & ~result.primary_over;
        comp_next.secondary_miss = bin_ok
                                   & ~result.secondary_in_bin;
        comp_next.secondary_reject = result.secondary_reject;
        comp_next.contact_fail = result.contact_fail;
        comp_next.fail = result.contact_fail | ~bin_ok
                         | (bin_ok & ~result.secondary_in_bin)
                         | result.other_segment_fail;
    end

    // Held from one result to the next, also across the next trigger
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            held_reg <= '0;
            last_bin_reg <= '0;
        end else if (result_taken) begin
            held_reg <= comp_next;
            last_bin_reg <= bin_ok ? result.bin : '0;
        end
    end

    // ****************************************************************
    // Pin stage
    // ****************************************************************
    // Comparator lines stay released while the enable bit is off.
    // A new result bypasses the hold register so that the lines move on
    // the same edge as cycle end; the handler never sees stale bins.
    oc_driver #(
        .WIDTH($bits(comparator_t))
    ) u_oc_driver (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(ctrl_reg[`CTRL_ENABLE]),
        .assert_bits(result_taken ? comp_next : held_reg),
        .level(comparator_level),
        .drive(comparator_drive)
    );

    // Protection bits are accepted and not checked
    logic unused_prot;
    assign unused_prot = ^{awprot, arprot, wstrb[3:1]};
endmodule // handler_bin_sort_outputs

// ---- tb/handler_bin_sort_outputs_sva.sv ----
// Checker of the handler comparator output stage.
// Assumes a bind to the top module; it sees that module's ports only.
`timescale 1ns/1ps

module bin_sort_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic meas_start,
    input wire handler_pkg::result_t result,
    input wire handler_pkg::comparator_t comparator_level,
    input wire handler_pkg::comparator_t comparator_drive,
    input wire logic measurement_cycle_end_n
);
    import handler_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ****************************************
    // Output line relations
    // ****************************************
    // Drive lands on the edge that lowers the cycle end mark
    sequence s_end;
        $fell(measurement_cycle_end_n) ##1 1'b1;
    endsequence
    property p_released;
        comparator_level == '0;
    endproperty
    a_released: assert property (p_released)
        else $error("comparator line driven high");
    property p_one_bin;
        $onehot0(comparator_drive.bin_lines);
    endproperty
    a_one_bin: assert property (p_one_bin)
        else $error("more than one bin line asserted");
    property p_over;
        comparator_drive.primary_over |-> comparator_drive.no_bin_match;
    endproperty
    a_over: assert property (p_over)
        else $error("over without no-bin-match");
    property p_under;
        comparator_drive.primary_under |-> comparator_drive.no_bin_match;
    endproperty
    a_under: assert property (p_under)
        else $error("under without no-bin-match");
    property p_fail;
        (comparator_drive.no_bin_match || comparator_drive.secondary_miss ||
            comparator_drive.contact_fail) |-> comparator_drive.fail;
    endproperty
    a_fail: assert property (p_fail)
        else $error("fail missing");
    property p_miss;
        comparator_drive.secondary_miss |->
            (|comparator_drive.bin_lines) && !comparator_drive.no_bin_match;
    endproperty
    a_miss: assert property (p_miss)
        else $error("secondary miss without a bin");
    property p_no_bin;
        comparator_drive.no_bin_match |-> comparator_drive.bin_lines == '0;
    endproperty
    a_no_bin: assert property (p_no_bin)
        else $error("bin line beside no-bin-match");
    property p_hold;
        s_end |=> $stable(comparator_drive) [*3];
    endproperty
    a_hold: assert property (p_hold)
        else $error("outputs moved after cycle end");
    property p_end_cause;
        $fell(measurement_cycle_end_n) |-> $past(result.valid);
    endproperty
    a_end_cause: assert property (p_end_cause)
        else $error("cycle end without a result");
    property p_start;
        meas_start |-> measurement_cycle_end_n [*2] ##0 !meas_start;
    endproperty
    a_start: assert property (p_start)
        else $error("cycle end kept through a start");
endmodule // bin_sort_checker

// ---- tb/handler_model.sv ----
// Model of the component handler on the far side of the pins.
// Assumes its task is called just after a rising edge of aclk.
`timescale 1ns/1ps

module handler_model (
    input wire logic aclk,
    input wire logic measurement_cycle_end_n,
    input wire handler_pkg::comparator_t comparator_drive,
    output logic external_trigger_n,
    output handler_pkg::comparator_t seen
);
    import handler_pkg::*;
    logic end_prev = 1'b1;
    initial external_trigger_n = 1'b1;

    // One low pulse gives both edges; the device keeps the chosen one
    task automatic pulse(input int width);
        external_trigger_n <= 1'b0;
        repeat (width) @(posedge aclk);
        external_trigger_n <= 1'b1;
    endtask

    // Results are read in the first cycle of cycle end low, so stale
    // lines at that point would be caught
    always @(posedge aclk) begin
        end_prev <= measurement_cycle_end_n;
        if (!measurement_cycle_end_n && end_prev) begin
            seen <= comparator_drive;
        end
    end
endmodule // handler_model

// ---- tb/handler_bin_sort_outputs_bench.sv ----
// Self-checking bench of the handler comparator output stage.
// Assumes the design, checker and handler model are compiled first.
`timescale 1ns/1ps
`include "handler_params.svh"

module handler_bin_sort_outputs_bench;
    import handler_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] awaddr = '0, araddr = '0;
    logic [2:0] awprot = '0, arprot = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, meas_start, irq;
    logic eom_n, trig_n, end_prev = 1'b1;
    logic [1:0] bresp, rresp;
    logic [3:0] sort_segment;
    logic [7:0] ctl;
    result_t result = '0, pend = '0, r;
    comparator_t c_level, c_drive, seen;
    int n_errors = 0, checks = 0, cyc = 0, n_end = 0;
    result_t corner [6] = '{11'h248, 11'h040, 11'h0f8, 11'h00c, 11'h3cb,
        11'h149};

    always #25 aclk = ~aclk;

    handler_bin_sort_outputs u_handler_bin_sort_outputs (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(arprot),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .meas_start(meas_start),
        .sort_segment(sort_segment), .result(result),
        .external_trigger_n(trig_n), .comparator_level(c_level),
        .comparator_drive(c_drive), .measurement_cycle_end_n(eom_n),
        .irq(irq));

    handler_model u_handler_model (
        .aclk(aclk), .measurement_cycle_end_n(eom_n),
        .comparator_drive(c_drive), .external_trigger_n(trig_n),
        .seen(seen));

    // ****************************************
    // Engine stand-in, cycle-end counter, timeout
    // ****************************************
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        end_prev <= eom_n;
        if (end_prev && !eom_n) begin
            n_end <= n_end + 1;
        end
        result <= meas_start ? {1'b1, pend[9:0]} : '0;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d,
            input logic [1:0] er);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge aclk);
            ta |= awvalid && awready;
            tw |= wvalid && wready;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b1;
        do @(negedge aclk); while (!bvalid);
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] ed,
            input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge aclk);
    endtask

    function automatic comparator_t exp_cmp(input result_t x);
        comparator_t c;
        logic ok;
        ok = x.bin >= 4'h1 && x.bin <= 4'h9;
        ok = ok && !x.primary_over && !x.primary_under;
        c = '0;
        if (ok) c.bin_lines[x.bin - 4'h1] = 1'b1;
        c.no_bin_match = !ok;
        c.primary_over = x.primary_over;
        c.primary_under = x.primary_under && !x.primary_over;
        c.secondary_miss = ok && !x.secondary_in_bin;
        c.secondary_reject = x.secondary_reject;
        c.contact_fail = x.contact_fail;
        c.fail = x.contact_fail || !ok || c.secondary_miss ||
            x.other_segment_fail;
        return c;
    endfunction

    // Counter of cycle ends catches a result that lands inside the write
    task automatic run(input result_t x, input logic [7:0] cv);
        int old;
        comparator_t c, e;
        old = n_end;
        c = exp_cmp(x);
        e = cv[0] ? c : '0;
        pend = x;
        wr(`OFF_CTRL, {24'h0, cv}, `RESP_OKAY);
        if (cv[2]) u_handler_model.pulse(4);
        repeat (200) begin
            @(negedge aclk);
            if (n_end != old) break;
        end
        chk(32'(n_end - old), 32'h1);
        chk({16'h0, c_drive}, {16'h0, e});
        chk({25'h0, c_drive[15:9]}, {25'h0, e[15:9]});
        chk({16'h0, c_level}, 32'h0);
        chk({28'h0, sort_segment}, {28'h0, cv[7:4]});
        repeat (2) @(posedge aclk);
        if (cv[0]) chk({16'h0, seen}, {16'h0, c});
        rd(`OFF_STATUS, {24'h0, (c.no_bin_match ? 4'h0 : x.bin),
            c.no_bin_match, c.fail, 2'b10}, `RESP_OKAY);
    endtask

    task automatic summarize();
        $display("TB: checks=%0d errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(66446));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFF_CTRL, `DATA_ZERO, `RESP_OKAY);
        rd(`OFF_STATUS, `DATA_ZERO, `RESP_OKAY);
        rd(`OFF_IRQ_MASK, `DATA_ZERO, `RESP_OKAY);
        rd(5'h14, `DATA_ZERO, `RESP_SLVERR);
        wr(5'h14, 32'hffff_ffff, `RESP_SLVERR);
        for (int i = 0; i < 40; i++) begin
            r = i < 6 ? corner[i] : result_t'($urandom);
            if (i >= 6 && $urandom % 2) begin
                r.primary_over = 1'b0;
                r.primary_under = 1'b0;
            end
            ctl = {4'($urandom), 4'h9};
            if (i % 3 != 0) begin
                ctl[3:0] = {2'b01, i % 3 == 2, 1'b1};
            end
            run(r, ctl);
        end
        // Sticky events stay pending while masked
        chk({31'h0, irq}, 32'h0);
        rd(`OFF_IRQ_STAT, 32'h0000_0007, `RESP_OKAY);
        wr(`OFF_IRQ_MASK, 32'h0000_0002, `RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        wr(`OFF_IRQ_STAT, 32'h0000_000f, `RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        rd(`OFF_IRQ_STAT, `DATA_ZERO, `RESP_OKAY);
        run(corner[1], 8'h08);
        rd(`OFF_COUNT, 32'h0000_0029, `RESP_OKAY);
        summarize();
    end
endmodule // handler_bin_sort_outputs_bench

bind handler_bin_sort_outputs bin_sort_checker u_bin_sort_checker (
    .aclk(aclk), .aresetn(aresetn), .meas_start(meas_start),
    .result(result), .comparator_level(comparator_level),
    .comparator_drive(comparator_drive),
    .measurement_cycle_end_n(measurement_cycle_end_n));
